// >>> afc_map.vh
/*
  Register map, field positions and reset values of the access fault
  capture block. Assumes a Wishbone slave with 32-bit data and word
  aligned registers; included by its bare name.
*/
`ifndef AFC_MAP_VH
`define AFC_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define AFC_ADDR_FAULT_RECORD  8'h00
`define AFC_ADDR_PC_CAPTURE    8'h04
`define AFC_ADDR_FLAGS_HIGH    8'h08
`define AFC_ADDR_FLAGS_LOW     8'h0C
`define AFC_ADDR_IRQ_STATUS    8'h10
`define AFC_ADDR_IRQ_MASK      8'h14

// Printed condition code byte addresses, kept as indices
`define AFC_IDX_FLAGS_HIGH     16'h0082
`define AFC_IDX_FLAGS_LOW      16'h0083

// ----------------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------------
`define AFC_KIND_MSB           7
`define AFC_KIND_LSB           4
`define AFC_VIOL_MSB           3
`define AFC_VIOL_LSB           0
`define AFC_KIND_NONE          4'h0
`define AFC_KIND_OPCODE        4'h1
`define AFC_KIND_VECTOR        4'h2
`define AFC_KIND_LOAD          4'h3
`define AFC_KIND_STORE         4'h4
`define AFC_VIOL_NONE          4'h0
`define AFC_VIOL_ILLEGAL       4'h1
`define AFC_VIOL_ECC           4'h2
`define AFC_CLEAR_PATTERN      16'hFFFF

// Interrupt status bits
`define AFC_IRQ_ILLEGAL        0
`define AFC_IRQ_ECC            1
`define AFC_IRQ_WIDTH          2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AFC_RST_RECORD         16'h0000
`define AFC_RST_MASK           2'h0

`endif

// >>> afc_wb_slave.v
/*
  Classic Wishbone slave front end for the access fault capture block.
  Answers every cycle with ack one clock after stb, drops it the next.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module afc_wb_slave (
  core_clk,
  rst_n,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_ack_o,
  wr_pulse,
  rd_pulse
);
  input  wire       core_clk;
  input  wire       rst_n;
  input  wire       wb_cyc_i;
  input  wire       wb_stb_i;
  input  wire       wb_we_i;
  output reg        wb_ack_o;
  output wire       wr_pulse;
  output wire       rd_pulse;

  wire req;

  // Accept a new request only when ack is not already out
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_pulse = req & wb_we_i;
  assign rd_pulse = req & ~wb_we_i;

  // ----------------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------------
  // One-cycle ack per request
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end
endmodule // afc_wb_slave

// >>> afc_irq.v
/*
  Sticky interrupt status with write-one-to-clear, mask and a level
  output. Assumes set and clear pulses in the core clock domain.
*/
`timescale 1ns/1ps
`include "afc_map.vh"

module afc_irq #(
  parameter W = `AFC_IRQ_WIDTH
) (
  core_clk,
  rst_n,
  set_i,
  clr_i,
  mask_wr,
  mask_d,
  status_o,
  mask_o,
  irq_o
);
  input  wire         core_clk;
  input  wire         rst_n;
  input  wire [W-1:0] set_i;
  input  wire [W-1:0] clr_i;
  input  wire         mask_wr;
  input  wire [W-1:0] mask_d;
  output reg  [W-1:0] status_o;
  output reg  [W-1:0] mask_o;
  output reg          irq_o;

  wire [W-1:0] status_nxt;

  // Set wins over a clear in the same cycle
  assign status_nxt = (status_o & ~clr_i) | set_i;

  // Status, mask and registered interrupt level
  always @(posedge core_clk) begin
    if (!rst_n) begin
      status_o <= {W{1'b0}};
      mask_o   <= `AFC_RST_MASK;
      irq_o    <= 1'b0;
    end else begin
      status_o <= status_nxt;
      if (mask_wr) begin
        mask_o <= mask_d;
      end
      irq_o <= |(status_nxt & (mask_wr ? mask_d : mask_o));
    end
  end
endmodule // afc_irq

// >>> afc_capture.v
/*
  Access fault capture: records access kind and violation kind of the
  first fault, latches program counter and condition code with it, and
  holds the record until software writes the clearing pattern.
  Assumes fault inputs are synchronous to core_clk, one-cycle pulses.
*/
`timescale 1ns/1ps
`include "afc_map.vh"

module afc_capture #(
  parameter PC_W = 24,
  parameter CC_W = 16
) (
  core_clk,
  rst_n,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_dat_i,
  wb_sel_i,
  wb_dat_o,
  wb_ack_o,
  fault_illegal,
  fault_ecc,
  fault_kind,
  core_pc,
  core_flags,
  irq,
  fault_held
);
  input  wire            core_clk;
  input  wire            rst_n;
  input  wire            wb_cyc_i;
  input  wire            wb_stb_i;
  input  wire            wb_we_i;
  input  wire [7:0]      wb_adr_i;
  input  wire [31:0]     wb_dat_i;
  input  wire [3:0]      wb_sel_i;
  output reg  [31:0]     wb_dat_o;
  output wire            wb_ack_o;
  input  wire            fault_illegal;
  input  wire            fault_ecc;
  input  wire [3:0]      fault_kind;
  input  wire [PC_W-1:0] core_pc;
  input  wire [CC_W-1:0] core_flags;
  output wire            irq;
  output reg             fault_held;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [15:0]     fault_record_r;
  reg  [15:0]     fault_record_nxt;
  reg  [PC_W-1:0] fault_pc_capture_r;
  reg  [CC_W-1:0] fault_flags_capture_r;
  reg  [31:0]     rd_nxt;
  reg  [3:0]      viol_code;
  wire            wr_pulse;
  wire            rd_pulse;
  wire            armed;
  wire            fault_any;
  wire            clear_hit;
  wire            mask_wr;
  wire            stat_wr;
  wire [1:0]      irq_status;
  wire [1:0]      irq_mask;
  wire [1:0]      irq_set;
  wire [1:0]      irq_clr;

  // Lane-aware 16-bit write test for the clearing pattern
  function is_clear;
    input [15:0] d;
    input [3:0]  s;
    begin
      is_clear = (s[1:0] == 2'b11) && (d == `AFC_CLEAR_PATTERN);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus front end and interrupts
  // ----------------------------------------------------------------------
  afc_wb_slave u_wb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_ack_o (wb_ack_o),
    .wr_pulse (wr_pulse),
    .rd_pulse (rd_pulse)
  );

  assign mask_wr = wr_pulse & (wb_adr_i == `AFC_ADDR_IRQ_MASK) & wb_sel_i[0];
  assign stat_wr = wr_pulse & (wb_adr_i == `AFC_ADDR_IRQ_STATUS)
                   & wb_sel_i[0];
  assign irq_clr = stat_wr ? wb_dat_i[1:0] : 2'b00;

  afc_irq #(
    .W (`AFC_IRQ_WIDTH)
  ) u_irq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .set_i    (irq_set),
    .clr_i    (irq_clr),
    .mask_wr  (mask_wr),
    .mask_d   (wb_dat_i[1:0]),
    .status_o (irq_status),
    .mask_o   (irq_mask),
    .irq_o    (irq)
  );

  // ----------------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------------
  // capture only when empty
  assign armed     = (fault_record_r == `AFC_RST_RECORD);
  assign fault_any = fault_illegal | fault_ecc;
  assign clear_hit = wr_pulse & (wb_adr_i == `AFC_ADDR_FAULT_RECORD)
                     & is_clear(wb_dat_i[15:0], wb_sel_i);
  // Interrupt events are the captures themselves
  assign irq_set   = (armed & fault_any) ?
                     {fault_ecc, ~fault_ecc} : 2'b00;

  // violation code, ECC ranks above illegal address
  always @* begin
    if (fault_ecc) begin
      viol_code = `AFC_VIOL_ECC;
    end else if (fault_illegal) begin
      viol_code = `AFC_VIOL_ILLEGAL;
    end else begin
      viol_code = `AFC_VIOL_NONE;
    end
  end

  // Next record value
  always @* begin
    fault_record_nxt = fault_record_r;
    if (armed && fault_any) begin
      fault_record_nxt = {8'h00, fault_kind, viol_code};
    end else if (clear_hit) begin
      fault_record_nxt = `AFC_RST_RECORD;
    end
  end

  // ----------------------------------------------------------------------
  // Capture registers
  // ----------------------------------------------------------------------
  // Record, PC and flags captured together; the clearing write resets only the record
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fault_record_r        <= `AFC_RST_RECORD;
      fault_pc_capture_r    <= {PC_W{1'b0}};
      fault_flags_capture_r <= {CC_W{1'b0}};
      fault_held            <= 1'b0;
    end else begin
      fault_record_r <= fault_record_nxt;
      fault_held     <= (fault_record_nxt != `AFC_RST_RECORD);
      if (armed && fault_any) begin
        fault_pc_capture_r    <= core_pc;
        fault_flags_capture_r <= core_flags;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Read mux; unmapped reads return zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `AFC_ADDR_FAULT_RECORD: rd_nxt[15:0] = fault_record_r;
      `AFC_ADDR_PC_CAPTURE:   rd_nxt[PC_W-1:0] = fault_pc_capture_r;
      `AFC_ADDR_FLAGS_HIGH:   rd_nxt[7:0] = fault_flags_capture_r[15:8];
      `AFC_ADDR_FLAGS_LOW:    rd_nxt[7:0] = fault_flags_capture_r[7:0];
      `AFC_ADDR_IRQ_STATUS:   rd_nxt[1:0] = irq_status;
      `AFC_ADDR_IRQ_MASK:     rd_nxt[1:0] = irq_mask;
      default:                rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data registered alongside ack
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_pulse) begin
      wb_dat_o <= rd_nxt;
    end
  end
endmodule // afc_capture

// >>> afc_capture_chk.sv
/* Port checker for the access fault capture block.
   Bound to afc_capture; sees its ports only, one clock domain. */
`timescale 1ns/1ps
`include "afc_map.vh"
module afc_capture_chk #(parameter CC_W = 16) (
  input wire            core_clk,
  input wire            rst_n,
  input wire            wb_cyc_i,
  input wire            wb_stb_i,
  input wire            wb_we_i,
  input wire [7:0]      wb_adr_i,
  input wire [31:0]     wb_dat_i,
  input wire [3:0]      wb_sel_i,
  input wire [31:0]     wb_dat_o,
  input wire            wb_ack_o,
  input wire            fault_illegal,
  input wire            fault_ecc,
  input wire [CC_W-1:0] core_flags,
  input wire            fault_held
);
  // Request taken, fault seen, clearing write, read answer
  wire hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ev  = fault_illegal || fault_ecc;
  wire clr = hit && wb_we_i && wb_adr_i == `AFC_ADDR_FAULT_RECORD &&
             wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == 16'hFFFF;
  wire rd  = wb_ack_o && !wb_we_i;
  reg [CC_W-1:0] cc_r;
  // Shadow of the flags taken with the first fault
  always @(posedge core_clk)
    if (!rst_n) cc_r <= {CC_W{1'b0}};
    else if (ev && !fault_held) cc_r <= core_flags;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  held_set_a: assert property (ev && !fault_held |=> fault_held)
    else $error("fault not captured");
  held_keep_a: assert property (fault_held && !clr |=> fault_held)
    else $error("record lost without clear");
  held_clear_a: assert property (fault_held && clr |=> !fault_held)
    else $error("clearing write ignored");
  held_idle_a: assert property (!fault_held && !ev |=> !fault_held)
    else $error("record set without fault");
  ack_next_a: assert property (hit |=> wb_ack_o)
    else $error("ack late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  flags_rd_a: assert property (rd && $stable(cc_r) &&
    wb_adr_i == `AFC_ADDR_FLAGS_LOW |-> wb_dat_o[7:0] == cc_r[7:0])
    else $error("flags low byte wrong");
  rec_rd_a: assert property (rd && wb_adr_i == 8'h00 &&
    $past(fault_held) |-> wb_dat_o[15:0] != 16'h0000)
    else $error("held record reads zero");
endmodule // afc_capture_chk

// >>> afc_core_model.sv
/* Core and memory side model: one-cycle fault reports on request,
   program counter and flags moving every cycle. */
`timescale 1ns/1ps
module afc_core_model (
  input  wire        core_clk,
  input  wire        go,
  input  wire        ill,
  input  wire        ecc,
  input  wire [3:0]  kind,
  output reg         fault_illegal = 1'b0,
  output reg         fault_ecc = 1'b0,
  output reg  [3:0]  fault_kind = 4'h0,
  output reg  [23:0] core_pc = 24'h00_0000,
  output wire [15:0] core_flags
);
  // Kind is scrambled between reports so stale values show
  always @(posedge core_clk) begin
    fault_illegal <= go & ill;
    fault_ecc     <= go & ecc;
    fault_kind    <= go ? kind : ~fault_kind;
    core_pc       <= core_pc + 24'h00_0003;
  end
  assign core_flags = {core_pc[7:0], ~core_pc[7:0]};
endmodule // afc_core_model

// >>> afc_capture_tb_top.sv
/* Self-checking bench of the access fault capture block.
   Drives Wishbone and the core model; expects afc_map.vh. */
`timescale 1ns/1ps
`include "afc_map.vh"
module afc_capture_tb_top;
  logic        core_clk = 0, rst_n = 0, go = 0, ill = 0, ecc = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, rd;
  logic [3:0]  wb_sel_i = 4'hF, kind = 0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, irq, fault_held, fault_illegal, fault_ecc;
  wire  [3:0]  fault_kind;
  wire  [23:0] core_pc;
  wire  [15:0] core_flags;
  logic [23:0] pc_x;
  logic [15:0] cc_x;
  int          err_total = 0, checks = 0;
  // Rows: bit13 illegal, bit12 ECC, kind, expected record byte
  logic [15:0] rows [6] = '{16'h2111, 16'h2221, 16'h2331, 16'h2441,
                            16'h1332, 16'h3112};
  afc_capture dut (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .fault_illegal(fault_illegal), .fault_ecc(fault_ecc),
    .fault_kind(fault_kind), .core_pc(core_pc),
    .core_flags(core_flags), .fault_held(fault_held));
  afc_core_model core (.core_clk(core_clk), .go(go), .ill(ill),
    .ecc(ecc), .kind(kind), .fault_illegal(fault_illegal),
    .fault_ecc(fault_ecc), .fault_kind(fault_kind),
    .core_pc(core_pc), .core_flags(core_flags));
  initial forever #10 core_clk = ~core_clk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask
  // One fault report; note what an armed capture should keep
  task fault(input logic i, input logic e, input logic [3:0] k);
    go <= 1;
    ill <= i;
    ecc <= e;
    kind <= k;
    @(posedge core_clk);
    go <= 0;
    @(posedge core_clk);
    if (fault_held !== 1'b1) begin
      pc_x = core_pc;
      cc_x = core_flags;
    end
    @(posedge core_clk);
  endtask
  task wrap_up;
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1;
    wb(0, `AFC_ADDR_IRQ_MASK, 0);
    chk("mask", 0, rd);
    foreach (rows[n]) begin
      fault(rows[n][13], rows[n][12], rows[n][11:8]);
      chk("held", 1, fault_held);
      wb(0, `AFC_ADDR_FAULT_RECORD, 0);
      chk("record", {24'h0, rows[n][7:0]}, rd);
      wb(1, `AFC_ADDR_FAULT_RECORD, 32'h0000_FFFF);
      chk("rearmed", 0, fault_held);
      wb(0, `AFC_ADDR_FAULT_RECORD, 0);
      chk("cleared", 0, rd);
    end
    fault(1, 0, `AFC_KIND_STORE);
    fault(0, 1, `AFC_KIND_LOAD);
    wb(1, `AFC_ADDR_FAULT_RECORD, 32'h0000_FFFE);
    wb(0, `AFC_ADDR_FAULT_RECORD, 0);
    chk("record kept", 32'h41, rd);
    wb(1, `AFC_ADDR_FLAGS_LOW, 32'h0000_00A5);
    wb(0, `AFC_ADDR_FAULT_RECORD, 0);
    chk("held record", 32'h41, rd);
    wb(0, `AFC_ADDR_PC_CAPTURE, 0);
    chk("pc", {8'h0, pc_x}, rd);
    wb(0, `AFC_ADDR_FLAGS_HIGH, 0);
    chk("flags high", {24'h0, cc_x[15:8]}, rd);
    wb(0, `AFC_ADDR_FLAGS_LOW, 0);
    chk("flags low", {24'h0, cc_x[7:0]}, rd);
    wb(0, 8'h3C, 0);
    chk("unmapped", 0, rd);
    // Interrupt: masked ECC event, unmasked illegal event, W1C
    wb(1, `AFC_ADDR_FAULT_RECORD, 32'h0000_FFFF);
    wb(1, `AFC_ADDR_IRQ_STATUS, 32'h0000_0003);
    wb(1, `AFC_ADDR_IRQ_MASK, 32'h0000_0001);
    fault(0, 1, `AFC_KIND_VECTOR);
    chk("irq masked", 0, irq);
    wb(1, `AFC_ADDR_FAULT_RECORD, 32'h0000_FFFF);
    fault(1, 0, `AFC_KIND_OPCODE);
    chk("irq", 1, irq);
    wb(1, `AFC_ADDR_IRQ_STATUS, 32'h0000_0001);
    chk("irq cleared", 0, irq);
    wb(0, `AFC_ADDR_IRQ_STATUS, 0);
    chk("status", 32'h2, rd);
    // Mid-run reset with a record held and the interrupt raised
    wb(1, `AFC_ADDR_FAULT_RECORD, 32'h0000_FFFF);
    fault(1, 0, `AFC_KIND_STORE);
    chk("irq before reset", 1, irq);
    rst_n <= 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1;
    chk("held after reset", 0, fault_held);
    chk("irq after reset", 0, irq);
    wb(0, `AFC_ADDR_FAULT_RECORD, 0);
    chk("record after reset", 0, rd);
    wb(0, `AFC_ADDR_IRQ_MASK, 0);
    chk("mask after reset", 0, rd);
    wb(0, `AFC_ADDR_IRQ_STATUS, 0);
    chk("status after reset", 0, rd);
    // Capture is armed again straight after reset
    fault(0, 1, `AFC_KIND_VECTOR);
    wb(0, `AFC_ADDR_FAULT_RECORD, 0);
    chk("record after rearm", 32'h22, rd);
    wrap_up;
  end
endmodule // afc_capture_tb_top
bind afc_capture afc_capture_chk #(.CC_W(CC_W)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .fault_illegal(fault_illegal),
  .fault_ecc(fault_ecc), .core_flags(core_flags),
  .fault_held(fault_held));
